// *** tb/dcc_control_monitor.sv ***
// Port checker for the control-command engine
`timescale 1ns/1ps
module dcc_control_monitor
#(
	parameter int DRIVES = 4,
	parameter int MS_CYC = 20
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Drive and setup outputs
	input wire logic [DRIVES-1:0] step_pulse_pin,
	input wire logic [DRIVES-1:0] step_way_pin,
	input wire logic [4:0] queue_level,
	input wire logic [7:0] write_comp_start_cyl,
	input wire logic irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	logic cmd_wr;
	logic qdis;
	assign cmd_wr = reg_wr && reg_addr == 4'h0;
	// Shadow of the queue-disable bit, seen from the register port
	always_ff @(posedge clk)
	begin
		if (rst)
			qdis <= 1'b1;
		else if (reg_wr && reg_addr == 4'h4)
			qdis <= reg_wdata[2];
	end
	chk_reset_setup_vals: assert property (
		$fell(rst) |-> queue_level == 5'h01 && write_comp_start_cyl == 8'h00)
		else $error("setup outputs wrong after reset");
	chk_qthr_level: assert property (
		reg_wr && reg_addr == 4'h5 && !qdis |-> ##2 queue_level == $past(reg_wdata[3:0], 2) + 5'h01)
		else $error("queue level does not follow threshold code");
	chk_write_comp_start_cyl_value: assert property (
		reg_wr && reg_addr == 4'h6 |-> ##2 write_comp_start_cyl == $past(reg_wdata, 2))
		else $error("precomp start track not taken");
	chk_sense_drops_irq: assert property (
		cmd_wr && reg_wdata[2:0] == 3'h3 |-> ##[1:3] !irq)
		else $error("interrupt sense left interrupt high");
	chk_sense_drv_quiet: assert property (
		cmd_wr && reg_wdata[2:0] == 3'h4 |=> !$rose(irq) [*8])
		else $error("drive status sense raised an interrupt");
	chk_recal_steps_out: assert property (
		cmd_wr && reg_wdata == 8'h01 |-> ##[1:600] step_pulse_pin[0] && !step_way_pin[0])
		else $error("recalibrate gave no outward step");
	chk_step_spacing: assert property (
		step_pulse_pin[0] |=> !step_pulse_pin[0] [*4])
		else $error("step pulses too close");
	chk_step_way_hold: assert property (
		step_pulse_pin[0] |=> $stable(step_way_pin[0]))
		else $error("direction changed right after a step");
	chk_rdata_hold: assert property (
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");
	chk_unmapped_zero: assert property (
		reg_rd && reg_addr > 4'hc |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	cov_step: cover property (step_pulse_pin[0]);
	cov_irq: cover property ($rose(irq));
	cov_par: cover property (step_pulse_pin[0] && step_pulse_pin[1] == 1'b0 ##[1:50] step_pulse_pin[1]);
endmodule

bind dcc_control dcc_control_monitor #(.DRIVES(DRIVES), .MS_CYC(MS_CYC)) u_mon (.*);

// *** tb/dcc_drive_model.sv ***
// Behavioural diskette drive: head position and track-zero sensor
`timescale 1ns/1ps
module dcc_drive_model
#(
	parameter int START_CYL = 3
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Head motion
	input wire logic step_pulse,
	input wire logic step_way,
	// Sensor fault on command of the bench
	input wire logic stuck,
	// Sensor
	output logic track_zero_pin
);
	int cyl;
	always_ff @(posedge clk)
	begin
		if (rst)
			cyl <= START_CYL;
		else if (step_pulse && step_way)
			cyl <= cyl + 1;
		else if (step_pulse && cyl > 0)
			cyl <= cyl - 1;
	end
	// High only at the outermost track
	assign track_zero_pin = cyl == 0 && !stuck;
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the control-command engine
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic mark_pin = 1'b0;
	logic tz;
	logic [3:0] dstat = 4'h0;
	logic [3:0] step_pulse_pin;
	logic [3:0] step_way_pin;
	logic id_valid = 1'b0;
	logic [7:0] id_cyl = 8'h00;
	logic [4:0] queue_level;
	logic [7:0] wcs;
	logic irq;
	logic stuck = 1'b0;
	logic rws = 1'b0;
	logic bneed = 1'b0;
	logic hload;
	logic rwgo;
	logic auto_seek;
	logic dreq;
	logic htr;
	logic [7:0] mflags;
	logic [7:0] v;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	int steps [2];
	logic way [2];
	always #2.5 clk = ~clk;
	dcc_control #(.DRIVES(4), .MS_CYC(20)) dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rotation_mark_pin(mark_pin), .track_zero_pin(tz), .drive_status_pins(dstat),
		.step_pulse_pin(step_pulse_pin), .step_way_pin(step_way_pin),
		.id_field_valid(id_valid), .id_field_cyl(id_cyl), .rw_start(rws), .rw_end(1'b0),
		.byte_needed(bneed), .head_load(hload), .rw_go(rwgo), .auto_seek_req(auto_seek),
		.dma_request(dreq), .host_transfer_request_bit(htr), .queue_level(queue_level),
		.write_comp_start_cyl(wcs), .mode_flags(mflags), .irq(irq));
	dcc_drive_model drv (.clk(clk), .rst(rst), .step_pulse(step_pulse_pin[0]),
		.step_way(step_way_pin[0]), .stuck(stuck), .track_zero_pin(tz));
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 12000)
		begin
			err_total++;
			end_of_test();
		end
		for (int i = 0; i < 2; i++)
			if (step_pulse_pin[i] === 1'b1)
			begin
				steps[i]++;
				way[i] = step_way_pin[i];
			end
	end
	task automatic end_of_test();
		$display("errors %0d of %0d checks", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic wait_irq(input int lim);
		for (int i = 0; i < lim && irq !== 1'b1; i++)
			@(posedge clk);
		chk({7'h00, irq}, 8'h01);
	endtask
	task automatic sense(input logic [7:0] exp);
		wr(4'h0, 8'h03);
		rd(4'h7, v);
		chk(v, exp);
		chk({7'h00, irq}, 8'h00);
	endtask
	task automatic seek(input logic [7:0] t, input int n, input logic w);
		steps[0] = 0;
		wr(4'h1, t);
		wr(4'h0, 8'h02);
		wait_irq(2000);
		chk(steps[0][7:0], n[7:0]);
		chk({7'h00, way[0]}, {7'h00, w});
		sense(8'h20);
		rd(4'ha, v);
		chk(v, t);
	endtask
	task automatic recal(input int n, input logic [7:0] st);
		steps[0] = 0;
		wr(4'h0, 8'h01);
		wait_irq(4000);
		chk(steps[0][7:0], n[7:0]);
		chk({7'h00, way[0]}, 8'h00);
		sense(st);
	endtask
	task automatic mark();
		mark_pin <= 1'b1;
		repeat (2) @(posedge clk);
		mark_pin <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		chk({3'h0, queue_level}, 8'h01);
		chk(wcs, 8'h00);
		wait_irq(10);
		sense(8'hc0);
		wr(4'h2, 8'hf0);
		recal(3, 8'h20);
		seek(8'h09, 9, 1'b1);
		seek(8'h04, 5, 1'b0);
		stuck <= 1'b1;
		recal(79, 8'h70);
		stuck <= 1'b0;
		// Two drives positioned at once
		steps = '{0, 0};
		wr(4'h1, 8'h02);
		wr(4'h0, 8'h02);
		wr(4'h1, 8'h12);
		wr(4'h0, 8'h12);
		wait_irq(2000);
		sense(8'h20);
		wait_irq(2000);
		sense(8'h21);
		chk(steps[1][7:0], 8'h12);
		rd(4'ha, v);
		chk(v, 8'h12);
		dstat <= 4'ha;
		wr(4'h0, 8'h04);
		repeat (8) @(posedge clk);
		chk({7'h00, irq}, 8'h00);
		rd(4'h8, v);
		chk({4'h0, v[3:0]}, 8'h0a);
		wr(4'h4, 8'h00);
		wr(4'h5, 8'h0f);
		@(posedge clk);
		#1;
		chk({3'h0, queue_level}, 8'h10);
		wr(4'h4, 8'h04);
		@(posedge clk);
		#1;
		chk({3'h0, queue_level}, 8'h01);
		wr(4'h6, 8'hff);
		@(posedge clk);
		#1;
		chk(wcs, 8'hff);
		wr(4'h5, 8'h00);
		@(posedge clk);
		#1;
		chk({3'h0, queue_level}, 8'h01);
		// Head load, settle and data-path requests
		wr(4'h4, 8'h44);
		wr(4'h3, 8'h02);
		rws <= 1'b1;
		@(posedge clk);
		rws <= 1'b0;
		bneed <= 1'b1;
		#1;
		chk({7'h00, auto_seek}, 8'h01);
		chk({7'h00, hload}, 8'h01);
		chk({7'h00, htr}, 8'h01);
		chk(mflags, 8'h44);
		@(posedge clk);
		bneed <= 1'b0;
		#1;
		chk({7'h00, dreq}, 8'h01);
		chk({7'h00, htr}, 8'h00);
		for (int i = 0; i < 60 && rwgo !== 1'b1; i++)
		begin
			@(posedge clk);
			#1;
		end
		chk({7'h00, rwgo}, 8'h01);
		wr(4'h4, 8'h04);
		rd(4'hf, v);
		chk(v, 8'h00);
		// ID read that never finds a field, then one that latches a field
		wr(4'h0, 8'h05);
		mark();
		repeat (4) @(posedge clk);
		chk({7'h00, irq}, 8'h00);
		mark();
		wait_irq(20);
		wr(4'h0, 8'h03);
		wr(4'h0, 8'h05);
		id_cyl <= 8'h2a;
		id_valid <= 1'b1;
		@(posedge clk);
		id_valid <= 1'b0;
		wait_irq(20);
		rd(4'h9, v);
		chk(v, 8'h2a);
		wr(4'h0, 8'h06);
		rd(4'ha, v);
		chk(v, 8'h00);
		end_of_test();
	end
endmodule

// *** verilog/dcc_cfg.svh ***
// Offsets, field positions, reset values and timing counts for the control-command engine
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH
`define DCC_CLK_MHZ 200
`define DCC_MS_CYC (`DCC_CLK_MHZ * 1000)
`define DCC_STEP_PULSE_US 2
`define DCC_STEP_PULSE_CYC (`DCC_STEP_PULSE_US * `DCC_CLK_MHZ)
`define DCC_RECAL_MAX_STEPS 79
`define DCC_SRT_BASE_MS 16
`define DCC_LONG_MS 256
`define DCC_HUT_UNIT_MS 16
`define DCC_HLT_UNIT_MS 2
// Register offsets
`define DCC_REG_CMD 4'h0
`define DCC_REG_TARGET 4'h1
`define DCC_REG_SPECIFY 4'h2
`define DCC_REG_HLT 4'h3
`define DCC_REG_CONFIG 4'h4
`define DCC_REG_QTHR 4'h5
`define DCC_REG_WRITE_COMP_START_CYL 4'h6
`define DCC_REG_ST0 4'h7
`define DCC_REG_ST3 4'h8
`define DCC_REG_IDFIELD 4'h9
`define DCC_REG_PCN 4'ha
`define DCC_REG_MAIN 4'hb
`define DCC_REG_RATE 4'hc
// Field positions
`define DCC_ST0_TZMISS 4
`define DCC_ST0_SEEKEND 5
// Reset values
`define DCC_CONFIG_RST 8'h04
`define DCC_SPECIFY_RST 8'h00
`endif

// *** verilog/dcc_control.sv ***
// Control-command engine: positioning, ID read, sense and setup commands
//
// What this block does
// - ID-read, recalibrate and seek completions, polling and programmed-I/O byte need raise the interrupt.
// - ID read latches first good ID; two marks without one sets 01 and miss.
// - Recalibrate clears cylinder, steps outward until track zero, then positioning_done.
// - Track zero missing after 79 steps sets positioning_done and track_zero_miss.
// - Busy only while a command is taken; positioning runs in background.
// - Seek steps inward with direction 1 or outward with direction 0.
// - Seek steps spaced by step interval; ends with positioning_done at equality.
// - Leaving power-down zeroes every cylinder and held status.
// - Interrupt on result phase, positioning end, or programmed-I/O byte need.
// - Interrupt sense clears interrupt and reports 0/11, 1/00 or 1/01.
// - Host must sense after positioning; head bit returned is always 0.
// - Drive-status sense returns status three with no execution phase.
// - Unload delay: code 0 is 256 ms, else n times 16 ms at 500K.
// - Step interval: 16 ms minus one per code at 500K.
// - Load settle: code 0 is 256 ms, else n times 2 ms at 500K.
// - All delays halve at 1M, quarter at 2M, double at 250K.
// - Programmed I/O uses request bit and interrupt; else DMA requests.
// - Auto-positioning enable seeks before each read or write; default off.
// - Queue disable, default 1, requests data byte by byte.
// - With polling on, one interrupt after reset; none while head loaded.
// - Queue threshold code 00 to 0F means one to sixteen bytes.
// - Write-comp start cylinder code selects track 0 to 255; default 0.
// - track_zero_miss is bit 4 of status_zero.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "dcc_cfg.svh"
module dcc_control
#(
	parameter int DRIVES = 4,
	parameter int MS_CYC = `DCC_MS_CYC
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Drive side
	input wire logic rotation_mark_pin,
	input wire logic track_zero_pin,
	input wire logic [DRIVES-1:0] drive_status_pins,
	output logic [DRIVES-1:0] step_pulse_pin,
	output logic [DRIVES-1:0] step_way_pin,
	// ID field from the read channel
	input wire logic id_field_valid,
	input wire logic [7:0] id_field_cyl,
	// Data path hooks
	input wire logic rw_start,
	input wire logic rw_end,
	input wire logic byte_needed,
	output logic head_load,
	output logic rw_go,
	output logic auto_seek_req,
	output logic dma_request,
	output logic host_transfer_request_bit,
	output logic [4:0] queue_level,
	output logic [7:0] write_comp_start_cyl,
	output logic [7:0] mode_flags,
	output logic irq
);
	import dcc_pkg::*;

	localparam logic [7:0] CFG_QDIS = 8'h04;
	localparam logic [7:0] CFG_POLLOFF = 8'h10;
	localparam logic [7:0] CFG_AUTOPOS = 8'h40;

	logic [7:0] present_cylinder [DRIVES];
	logic [7:0] target_cylinder [DRIVES];
	logic [DRIVES-1:0] pos_active;
	logic [DRIVES-1:0] pos_recal;
	logic [DRIVES-1:0] pos_done;
	logic [DRIVES-1:0] pos_fail;
	logic [6:0] steps_left [DRIVES];
	logic [31:0] step_timer [DRIVES];
	logic [7:0] specify_reg;
	logic [6:0] load_settle_code;
	logic programmed_io_select;
	logic [7:0] config_reg;
	logic [3:0] queue_threshold;
	logic [7:0] write_comp_start_cyl_reg;
	dcc_rate_t rate_sel;
	logic [1:0] term_code;
	logic id_absent_flag;
	logic [7:0] id_latch;
	logic [1:0] last_drive;
	logic [7:0] last_st0;
	logic busy;
	logic poll_irq;
	logic id_irq;
	logic xfer_irq;
	logic [7:0] st0_hold;
	dcc_id_e id_state;
	logic [1:0] mark_count;
	logic mark_d;
	logic [31:0] load_timer;
	logic [31:0] unload_timer;
	logic head_loaded;
	logic [2:0] cmd_code;
	logic [1:0] cmd_drive;
	logic cmd_wr;
	logic sense_int;
	logic [1:0] sense_drv;
	logic sense_pick;

	assign cmd_wr = reg_wr && reg_addr == `DCC_REG_CMD;
	assign cmd_code = reg_wdata[2:0];
	assign cmd_drive = reg_wdata[5:4];
	assign sense_int = cmd_wr && cmd_code == DCC_CMD_SENSE_INT;

	// Scale a 500K millisecond figure by rate: 0=500K 1=1M 2=2M 3=250K
	function automatic logic [31:0] scale(input logic [31:0] cyc, input dcc_rate_t r);
		logic [31:0] v;
		v = cyc;
		unique case (r)
			2'd1: v = cyc >> 1;
			2'd2: v = cyc >> 2;
			2'd3: v = cyc << 1;
			default: v = cyc;
		endcase
		return v;
	endfunction

	logic [31:0] step_cyc;
	logic [31:0] unload_cyc;
	logic [31:0] settle_cyc;
	always_comb
	begin
		step_cyc = scale(32'(`DCC_SRT_BASE_MS - specify_reg[7:4]) * 32'(MS_CYC), rate_sel);
		if (specify_reg[3:0] == 4'h0)
			unload_cyc = scale(32'(`DCC_LONG_MS) * 32'(MS_CYC), rate_sel);
		else
			unload_cyc = scale(32'(specify_reg[3:0]) * 32'(`DCC_HUT_UNIT_MS) * 32'(MS_CYC),
				rate_sel);
		if (load_settle_code == 7'h00)
			settle_cyc = scale(32'(`DCC_LONG_MS) * 32'(MS_CYC), rate_sel);
		else
			settle_cyc = scale(32'(load_settle_code) * 32'(`DCC_HLT_UNIT_MS) * 32'(MS_CYC),
				rate_sel);
	end

	// Setup registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			specify_reg <= `DCC_SPECIFY_RST;
			load_settle_code <= 7'h00;
			programmed_io_select <= 1'b0;
			config_reg <= `DCC_CONFIG_RST;
			queue_threshold <= 4'h0;
			write_comp_start_cyl_reg <= 8'h00;
			rate_sel <= 2'd0;
		end
		else if (reg_wr)
		begin
			unique case (reg_addr)
				`DCC_REG_SPECIFY: specify_reg <= reg_wdata;
				`DCC_REG_HLT:
				begin
					load_settle_code <= reg_wdata[7:1];
					programmed_io_select <= reg_wdata[0];
				end
				`DCC_REG_CONFIG: config_reg <= reg_wdata;
				`DCC_REG_QTHR: queue_threshold <= reg_wdata[3:0];
				`DCC_REG_WRITE_COMP_START_CYL: write_comp_start_cyl_reg <= reg_wdata;
				`DCC_REG_RATE: rate_sel <= reg_wdata[1:0];
				default: ;
			endcase
		end
	end

	// Per-drive positioning engines
	genvar g;
	generate
		for (g = 0; g < DRIVES; g++)
		begin : gen_drive
			logic start;
			logic tick;
			assign start = cmd_wr && cmd_drive == 2'(g) &&
				(cmd_code == DCC_CMD_SEEK || cmd_code == DCC_CMD_RECAL);
			assign tick = pos_active[g] && step_timer[g] == 32'd0;
			always_ff @(posedge clk)
			begin
				if (rst || (cmd_wr && cmd_code == DCC_CMD_POWER_UP))
				begin
					present_cylinder[g] <= 8'h00;
					target_cylinder[g] <= 8'h00;
					pos_active[g] <= 1'b0;
					pos_recal[g] <= 1'b0;
					pos_done[g] <= 1'b0;
					pos_fail[g] <= 1'b0;
					steps_left[g] <= 7'd0;
					step_timer[g] <= 32'd0;
					step_pulse_pin[g] <= 1'b0;
					step_way_pin[g] <= 1'b0;
				end
				else
				begin
					step_pulse_pin[g] <= 1'b0;
					if (step_timer[g] != 32'd0)
						step_timer[g] <= step_timer[g] - 32'd1;
					if (reg_wr && reg_addr == `DCC_REG_TARGET && cmd_drive == 2'(g))
						target_cylinder[g] <= reg_wdata;
					if (sense_int && sense_pick && sense_drv == 2'(g))
					begin
						pos_done[g] <= 1'b0;
						pos_fail[g] <= 1'b0;
					end
					if (start)
					begin
						pos_active[g] <= 1'b1;
						pos_recal[g] <= cmd_code == DCC_CMD_RECAL;
						pos_done[g] <= 1'b0;
						pos_fail[g] <= 1'b0;
						steps_left[g] <= 7'(`DCC_RECAL_MAX_STEPS);
						step_timer[g] <= `DCC_STEP_PULSE_CYC; // shorter first interval
						if (cmd_code == DCC_CMD_RECAL)
						begin
							present_cylinder[g] <= 8'h00;
							step_way_pin[g] <= 1'b0;
						end
					end
					else if (tick && pos_recal[g])
					begin
						if (track_zero_pin)
						begin
							pos_active[g] <= 1'b0;
							pos_done[g] <= 1'b1;
						end
						else if (steps_left[g] == 7'd0)
						begin
							pos_active[g] <= 1'b0;
							pos_done[g] <= 1'b1;
							pos_fail[g] <= 1'b1;
						end
						else
						begin
							step_pulse_pin[g] <= 1'b1;
							steps_left[g] <= steps_left[g] - 7'd1;
							step_timer[g] <= step_cyc;
						end
					end
					else if (tick)
					begin
						if (present_cylinder[g] == target_cylinder[g])
						begin
							pos_active[g] <= 1'b0;
							pos_done[g] <= 1'b1;
						end
						else
						begin
							step_pulse_pin[g] <= 1'b1;
							step_way_pin[g] <= present_cylinder[g] < target_cylinder[g];
							if (present_cylinder[g] < target_cylinder[g])
								present_cylinder[g] <= present_cylinder[g] + 8'd1;
							else
								present_cylinder[g] <= present_cylinder[g] - 8'd1;
							step_timer[g] <= step_cyc;
						end
					end
				end
			end
		end
	endgenerate

	// Lowest drive with a pending positioning end
	always_comb
	begin
		sense_pick = 1'b0;
		sense_drv = 2'd0;
		for (int i = DRIVES - 1; i >= 0; i--)
		begin
			if (pos_done[i])
			begin
				sense_pick = 1'b1;
				sense_drv = 2'(i);
			end
		end
	end

	// ID read: two rotation marks without an ID field ends it abnormally
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			id_state <= DCC_ID_IDLE;
			mark_count <= 2'd0;
			mark_d <= 1'b0;
			id_latch <= 8'h00;
			id_absent_flag <= 1'b0;
		end
		else
		begin
			mark_d <= rotation_mark_pin;
			unique case (id_state)
				DCC_ID_IDLE:
					if (cmd_wr && cmd_code == DCC_CMD_READ_ID)
					begin
						id_state <= DCC_ID_SEARCH;
						mark_count <= 2'd0;
						id_absent_flag <= 1'b0;
					end
				DCC_ID_SEARCH:
					if (id_field_valid)
					begin
						id_latch <= id_field_cyl;
						id_state <= DCC_ID_DONE;
					end
					else if (rotation_mark_pin && !mark_d)
					begin
						mark_count <= mark_count + 2'd1;
						if (mark_count == 2'd1)
						begin
							id_absent_flag <= 1'b1;
							id_state <= DCC_ID_MISS;
						end
					end
				DCC_ID_DONE: id_state <= DCC_ID_IDLE;
				DCC_ID_MISS: id_state <= DCC_ID_IDLE;
			endcase
		end
	end

	// Head load, settle and unload timing
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			head_loaded <= 1'b0;
			head_load <= 1'b0;
			rw_go <= 1'b0;
			load_timer <= 32'd0;
			unload_timer <= 32'd0;
			auto_seek_req <= 1'b0;
		end
		else
		begin
			rw_go <= 1'b0;
			auto_seek_req <= rw_start && config_reg[6];
			if (rw_start)
			begin
				head_loaded <= 1'b1;
				head_load <= 1'b1;
				load_timer <= settle_cyc;
			end
			else if (load_timer != 32'd0)
			begin
				load_timer <= load_timer - 32'd1;
				rw_go <= load_timer == 32'd1;
			end
			if (rw_end)
				unload_timer <= unload_cyc;
			else if (unload_timer != 32'd0)
			begin
				unload_timer <= unload_timer - 32'd1;
				if (unload_timer == 32'd1)
				begin
					head_loaded <= 1'b0;
					head_load <= 1'b0;
				end
			end
		end
	end

	// Interrupt sources and sense results
	always_ff @(posedge clk)
	begin
		if (rst || (cmd_wr && cmd_code == DCC_CMD_POWER_UP))
		begin
			poll_irq <= !config_reg[4] && !head_loaded;
			id_irq <= 1'b0;
			xfer_irq <= 1'b0;
			term_code <= 2'b00;
			last_st0 <= 8'h00;
			last_drive <= 2'd0;
			irq <= 1'b0;
		end
		else
		begin
			if (sense_int)
			begin
				poll_irq <= 1'b0;
				id_irq <= 1'b0;
				xfer_irq <= 1'b0;
				if (poll_irq)
					last_st0 <= {2'b11, 6'b000000};
				else if (sense_pick)
					last_st0 <= {1'b0, pos_fail[sense_drv], 1'b1, pos_fail[sense_drv],
						1'b0, 1'b0, sense_drv};
				else
					last_st0 <= {term_code, 6'b000000};
				last_drive <= sense_drv;
			end
			// Sources set after the sense clear, so a new event wins
			if (id_state == DCC_ID_DONE || id_state == DCC_ID_MISS)
			begin
				id_irq <= 1'b1;
				term_code <= id_state == DCC_ID_MISS ? 2'b01 : 2'b00;
			end
			if (byte_needed && programmed_io_select)
				xfer_irq <= 1'b1;
			irq <= poll_irq || id_irq || xfer_irq || (|pos_done);
		end
	end

	assign busy = cmd_wr;

	// Mode outputs
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			dma_request <= 1'b0;
			host_transfer_request_bit <= 1'b0;
			queue_level <= 5'd1;
			write_comp_start_cyl <= 8'h00;
			mode_flags <= 8'h00;
		end
		else
		begin
			dma_request <= byte_needed && !programmed_io_select;
			host_transfer_request_bit <= !busy &&
				(!byte_needed || programmed_io_select);
			queue_level <= config_reg[2] ? 5'd1 : 5'(queue_threshold) + 5'd1;
			write_comp_start_cyl <= write_comp_start_cyl_reg;
			mode_flags <= config_reg & (CFG_QDIS | CFG_POLLOFF | CFG_AUTOPOS);
		end
	end

	// Register read port
	always_ff @(posedge clk)
	begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				`DCC_REG_TARGET: reg_rdata <= target_cylinder[last_drive];
				`DCC_REG_SPECIFY: reg_rdata <= specify_reg;
				`DCC_REG_HLT: reg_rdata <= {load_settle_code, programmed_io_select};
				`DCC_REG_CONFIG: reg_rdata <= config_reg;
				`DCC_REG_QTHR: reg_rdata <= {4'h0, queue_threshold};
				`DCC_REG_WRITE_COMP_START_CYL: reg_rdata <= write_comp_start_cyl_reg;
				`DCC_REG_ST0: reg_rdata <= last_st0;
				`DCC_REG_ST3: reg_rdata <= {track_zero_pin, 3'b000,
					4'(drive_status_pins)};
				`DCC_REG_IDFIELD: reg_rdata <= id_latch;
				`DCC_REG_PCN: reg_rdata <= present_cylinder[last_drive];
				`DCC_REG_MAIN: reg_rdata <= {id_absent_flag, id_state != DCC_ID_IDLE,
					2'b00, 4'(pos_active)};
				`DCC_REG_RATE: reg_rdata <= {6'h00, rate_sel};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end
endmodule

// *** verilog/dcc_pkg.sv ***
// Types for the control-command engine
package dcc_pkg;
	typedef enum logic [2:0]
	{
		DCC_CMD_NONE = 3'h0,
		DCC_CMD_RECAL = 3'h1,
		DCC_CMD_SEEK = 3'h2,
		DCC_CMD_SENSE_INT = 3'h3,
		DCC_CMD_SENSE_DRV = 3'h4,
		DCC_CMD_READ_ID = 3'h5,
		DCC_CMD_POWER_UP = 3'h6
	} dcc_cmd_e;
	typedef enum logic [3:0]
	{
		DCC_ID_IDLE = 4'b0001,
		DCC_ID_SEARCH = 4'b0010,
		DCC_ID_DONE = 4'b0100,
		DCC_ID_MISS = 4'b1000
	} dcc_id_e;
	typedef logic [1:0] dcc_rate_t;
endpackage
